//--- include/wdrnm_consts.svh
// named offsets, field positions, reset values and timing counts for the watchdog
`ifndef WDRNM_CONSTS_SVH
`define WDRNM_CONSTS_SVH

// register indexes; byte address is four times the index
`define WDRNM_IDX_CONTROL     12'h093
`define WDRNM_IDX_RESTART     12'h094
`define WDRNM_IDX_IRQ_STATUS  12'h095
`define WDRNM_IDX_IRQ_MASK    12'h096
`define WDRNM_ADDR_W          12

// control register fields
`define WDRNM_CTL_EN_BIT      7
`define WDRNM_CTL_NMI_BIT     6
`define WDRNM_CTL_FLAG_BIT    5
`define WDRNM_CTL_CLK_HI      4
`define WDRNM_CTL_CLK_LO      3
`define WDRNM_CTL_PER_HI      1
`define WDRNM_CTL_PER_LO      0

// count clock select codes
`define WDRNM_CLK_SYSTEM      2'h0
`define WDRNM_CLK_REALTIME    2'h1

// terminal counts (period minus one) for the four period codes
`define WDRNM_CNT_W           27
`define WDRNM_LAST_P0         27'h7FFFFFF
`define WDRNM_LAST_P1         27'h1FFFFFF
`define WDRNM_LAST_P2         27'h03FFFFF
`define WDRNM_LAST_P3         27'h003FFFF
`define WDRNM_CNT_ZERO        27'h0000000
`define WDRNM_CNT_ONE         27'h0000001

// restart unlock bytes
`define WDRNM_KEY_FIRST       8'hA5
`define WDRNM_KEY_SECOND      8'h5A

// interrupt status and mask bits
`define WDRNM_IRQ_NMI_BIT     0
`define WDRNM_IRQ_TMO_BIT     1
`define WDRNM_IRQ_W           2

// reset values and bus answers
`define WDRNM_BYTE_ZERO       8'h00
`define WDRNM_IRQ_ZERO        2'h0
`define WDRNM_WORD_ZERO       32'h00000000
`define WDRNM_RESP_OKAY       2'h0
`define WDRNM_RESP_SLVERR     2'h2

`endif

//--- include/wdrnm_pkg.sv
// types shared by the watchdog design
package wdrnm_pkg;

	// decoded register selected by a bus address
	typedef enum {
		WDRNM_SEL_CONTROL,
		WDRNM_SEL_RESTART,
		WDRNM_SEL_STATUS,
		WDRNM_SEL_MASK,
		WDRNM_SEL_NONE
	} wdrnm_sel_t;

	// unlock sequence progress
	typedef enum {
		WDRNM_KEY_IDLE,
		WDRNM_KEY_ARMED
	} wdrnm_key_t;

endpackage : wdrnm_pkg

//--- verilog/wdrnm_top.sv
// watchdog timer with reset or nmi response, axi4-lite register slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wdrnm_consts.svh"

// Notes on behaviour
// - watchdog leaves every reset disabled; counting starts once software sets enable bit 7
// - writing zero to a set enable bit does nothing; only reset clears it
// - period field bits 1:0 select 2^27, 2^25, 2^22 or 2^18 counted cycles
// - clock select bits 4:3: 00 system clock, 01 real-time source, others reserved
// - each time-out sets read-only flag bit 5, for reset and nmi responses alike
// - time-out flag survives a watchdog reset; other resets clear it
// - bit 6 picks the action: 0 resets the cpu, 1 raises nmi
// - reset and nmi outputs change only on a rising clock edge
// - with nmi selected a time-out sets an interrupt-source flag software can poll
// - writing A5h then 5Ah to the restart register reloads the count, counting goes on
// - any delay between the two unlock writes is accepted while no time-out occurs
// - restart register is 8-bit write only; it only feeds the unlock detector
module wdrnm_top
	import wdrnm_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        NRST,
	input  wire logic        RST_BY_WATCHDOG,
	input  wire logic        RTC_TICK,
	input  wire logic [31:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [31:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output logic             CPU_RESET_REQ,
	output logic             CPU_NMI,
	output logic             IRQ
);

	// decode a byte address into a register; only aligned words within range match
	function automatic wdrnm_sel_t decode_addr(input logic [31:0] addr);
		logic [29:0] idx;
		idx = addr[31:2];
		if (addr[1:0] != 2'h0)
			return WDRNM_SEL_NONE;
		else if (idx == 30'(`WDRNM_IDX_CONTROL))
			return WDRNM_SEL_CONTROL;
		else if (idx == 30'(`WDRNM_IDX_RESTART))
			return WDRNM_SEL_RESTART;
		else if (idx == 30'(`WDRNM_IDX_IRQ_STATUS))
			return WDRNM_SEL_STATUS;
		else if (idx == 30'(`WDRNM_IDX_IRQ_MASK))
			return WDRNM_SEL_MASK;
		else
			return WDRNM_SEL_NONE;
	endfunction

	// last count value of a period code
	function automatic logic [`WDRNM_CNT_W-1:0] last_count(input logic [1:0] code);
		case (code)
			2'h0:    return `WDRNM_LAST_P0;
			2'h1:    return `WDRNM_LAST_P1;
			2'h2:    return `WDRNM_LAST_P2;
			default: return `WDRNM_LAST_P3;
		endcase
	endfunction

	// bus slave state
	logic        awready_ff;
	logic        wready_ff;
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [31:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	// watchdog state
	logic                     enable_ff;
	logic                     nmi_sel_ff;
	logic                     flag_ff;
	logic [1:0]               clk_sel_ff;
	logic [1:0]               period_ff;
	logic [`WDRNM_CNT_W-1:0]  count_ff;
	logic [`WDRNM_CNT_W-1:0]  nxt_count;
	wdrnm_key_t               key_ff;
	logic                     cpu_reset_ff;
	logic                     cpu_nmi_ff;
	logic [`WDRNM_IRQ_W-1:0]  irq_status_ff;
	logic [`WDRNM_IRQ_W-1:0]  irq_mask_ff;
	logic                     irq_ff;

	// combinational helpers
	logic       aw_take;
	logic       w_take;
	logic       ar_take;
	logic       wr_fire;
	logic       byte_ok;
	logic [7:0] wr_byte;
	wdrnm_sel_t wr_sel;
	wdrnm_sel_t rd_sel;
	logic       tick;
	logic       timeout;
	logic       key_done;
	logic       ctl_wr;
	logic       key_wr;
	logic       stat_wr;
	logic       mask_wr;

	assign aw_take = S_AXI_AWVALID & awready_ff;
	assign w_take  = S_AXI_WVALID & wready_ff;
	assign ar_take = S_AXI_ARVALID & arready_ff;
	// write happens one edge after both halves are held and no response waits
	assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign wr_sel  = decode_addr(awaddr_ff);
	assign rd_sel  = decode_addr(S_AXI_ARADDR);
	assign byte_ok = wstrb_ff[0];
	assign wr_byte = wdata_ff[7:0];
	assign ctl_wr  = wr_fire & byte_ok & (wr_sel == WDRNM_SEL_CONTROL);
	assign key_wr  = wr_fire & byte_ok & (wr_sel == WDRNM_SEL_RESTART);
	assign stat_wr = wr_fire & byte_ok & (wr_sel == WDRNM_SEL_STATUS);
	assign mask_wr = wr_fire & byte_ok & (wr_sel == WDRNM_SEL_MASK);

	// write address and data channels, taken in either order
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awaddr_ff  <= `WDRNM_WORD_ZERO;
			wdata_ff   <= `WDRNM_WORD_ZERO;
			wstrb_ff   <= 4'h0;
		end else begin
			if (aw_take) begin
				awaddr_ff  <= S_AXI_AWADDR;
				aw_held_ff <= 1'b1;
				awready_ff <= 1'b0;
			end
			if (w_take) begin
				wdata_ff  <= S_AXI_WDATA;
				wstrb_ff  <= S_AXI_WSTRB;
				w_held_ff <= 1'b1;
				wready_ff <= 1'b0;
			end
			// channels reopen only once the response is taken: one write at a time
			if (bvalid_ff && S_AXI_BREADY) begin
				aw_held_ff <= 1'b0;
				w_held_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// write response; unmapped address answers slverr, a missing low byte lane answers okay and writes nothing
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `WDRNM_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (wr_sel == WDRNM_SEL_NONE) ? `WDRNM_RESP_SLVERR : `WDRNM_RESP_OKAY;
		end else if (bvalid_ff && S_AXI_BREADY) begin
			bvalid_ff <= 1'b0;
		end
	end

	// read channel; data sampled at the address edge, restart key reads zero
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= `WDRNM_WORD_ZERO;
			rresp_ff   <= `WDRNM_RESP_OKAY;
		end else if (ar_take) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= `WDRNM_RESP_OKAY;
			rdata_ff   <= `WDRNM_WORD_ZERO;
			case (rd_sel)
				WDRNM_SEL_CONTROL: begin
					rdata_ff[`WDRNM_CTL_EN_BIT]                     <= enable_ff;
					rdata_ff[`WDRNM_CTL_NMI_BIT]                    <= nmi_sel_ff;
					rdata_ff[`WDRNM_CTL_FLAG_BIT]                   <= flag_ff;
					rdata_ff[`WDRNM_CTL_CLK_HI:`WDRNM_CTL_CLK_LO]   <= clk_sel_ff;
					rdata_ff[`WDRNM_CTL_PER_HI:`WDRNM_CTL_PER_LO]   <= period_ff;
				end
				WDRNM_SEL_RESTART: rdata_ff <= `WDRNM_WORD_ZERO; // write only
				WDRNM_SEL_STATUS:  rdata_ff[`WDRNM_IRQ_W-1:0] <= irq_status_ff;
				WDRNM_SEL_MASK:    rdata_ff[`WDRNM_IRQ_W-1:0] <= irq_mask_ff;
				default:           rresp_ff <= `WDRNM_RESP_SLVERR;
			endcase
		end else if (rvalid_ff && S_AXI_RREADY) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// control fields; enable is sticky so a zero write cannot stop a running watchdog
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			enable_ff  <= 1'b0;
			nmi_sel_ff <= 1'b0; // reset response by default
			clk_sel_ff <= `WDRNM_CLK_SYSTEM;
			period_ff  <= 2'h0;
		end else if (ctl_wr) begin
			enable_ff  <= enable_ff | wr_byte[`WDRNM_CTL_EN_BIT];
			nmi_sel_ff <= wr_byte[`WDRNM_CTL_NMI_BIT];
			clk_sel_ff <= wr_byte[`WDRNM_CTL_CLK_HI:`WDRNM_CTL_CLK_LO];
			period_ff  <= wr_byte[`WDRNM_CTL_PER_HI:`WDRNM_CTL_PER_LO];
		end
	end

	// count source: every system clock, one real-time pulse, or nothing when reserved
	always_comb begin
		case (clk_sel_ff)
			`WDRNM_CLK_SYSTEM:   tick = 1'b1;
			`WDRNM_CLK_REALTIME: tick = RTC_TICK;
			default:             tick = 1'b0;
		endcase
	end

	assign timeout  = enable_ff & tick & (count_ff == last_count(period_ff));
	// unlock completes on a second byte of 5Ah while armed
	assign key_done = key_wr & (key_ff == WDRNM_KEY_ARMED) & (wr_byte == `WDRNM_KEY_SECOND);

	// counter next value; restart wins over an ordinary tick
	always_comb begin
		nxt_count = count_ff;
		if (!enable_ff)
			nxt_count = `WDRNM_CNT_ZERO; // start from zero on enable
		else if (key_done || timeout)
			nxt_count = `WDRNM_CNT_ZERO; // reload and keep counting
		else if (tick)
			nxt_count = count_ff + `WDRNM_CNT_ONE;
	end

	// supervision counter
	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			count_ff <= `WDRNM_CNT_ZERO;
		else
			count_ff <= nxt_count;
	end

	// unlock detector; the armed state waits forever, only a time-out, the closing 5Ah or a bad byte drops it
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			key_ff <= WDRNM_KEY_IDLE;
		end else if (timeout) begin
			key_ff <= WDRNM_KEY_IDLE; // sequence must finish before a time-out
		end else if (key_wr) begin
			case (key_ff)
				WDRNM_KEY_IDLE: key_ff <= (wr_byte == `WDRNM_KEY_FIRST) ?
					WDRNM_KEY_ARMED : WDRNM_KEY_IDLE;
				WDRNM_KEY_ARMED: begin
					// a repeated A5h keeps it armed, any other byte, 5Ah included, drops it
					if (wr_byte == `WDRNM_KEY_FIRST)
						key_ff <= WDRNM_KEY_ARMED;
					else
						key_ff <= WDRNM_KEY_IDLE;
				end
				default: key_ff <= WDRNM_KEY_IDLE;
			endcase
		end
	end

	// time-out flag: kept through a watchdog reset, cleared by any other reset
	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			flag_ff <= flag_ff & RST_BY_WATCHDOG;
		else if (timeout)
			flag_ff <= 1'b1;
	end

	// reset request holds until the chip reset arrives; registered so edges are clocked
	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			cpu_reset_ff <= 1'b0;
		else if (timeout && !nmi_sel_ff)
			cpu_reset_ff <= 1'b1;
	end

	// nmi is a one-cycle pulse per time-out
	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			cpu_nmi_ff <= 1'b0;
		else
			cpu_nmi_ff <= timeout & nmi_sel_ff;
	end

	// sticky status: set beats a same-cycle write-one clear
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			irq_status_ff <= `WDRNM_IRQ_ZERO;
		end else begin
			for (int i = 0; i < `WDRNM_IRQ_W; i++) begin
				if (stat_wr && wr_byte[i])
					irq_status_ff[i] <= 1'b0;
			end
			if (timeout && nmi_sel_ff)
				irq_status_ff[`WDRNM_IRQ_NMI_BIT] <= 1'b1;
			if (timeout)
				irq_status_ff[`WDRNM_IRQ_TMO_BIT] <= 1'b1;
		end
	end

	// interrupt mask
	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			irq_mask_ff <= `WDRNM_IRQ_ZERO;
		else if (mask_wr)
			irq_mask_ff <= wr_byte[`WDRNM_IRQ_W-1:0];
	end

	// interrupt output, one cycle behind the status it reflects
	always_ff @(posedge CLK_SYS) begin
		if (!NRST)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_status_ff & irq_mask_ff);
	end

	assign S_AXI_AWREADY = awready_ff;
	assign S_AXI_WREADY  = wready_ff;
	assign S_AXI_BVALID  = bvalid_ff;
	assign S_AXI_BRESP   = bresp_ff;
	assign S_AXI_ARREADY = arready_ff;
	assign S_AXI_RVALID  = rvalid_ff;
	assign S_AXI_RDATA   = rdata_ff;
	assign S_AXI_RRESP   = rresp_ff;
	assign CPU_RESET_REQ = cpu_reset_ff;
	assign CPU_NMI       = cpu_nmi_ff;
	assign IRQ           = irq_ff;

endmodule // wdrnm_top

//--- tb/wdrnm_checker.sv
// port assertions for the watchdog top level and the bind that attaches them
`timescale 1ns/1ps
`include "wdrnm_consts.svh"
module wdrnm_checker (
	input wire logic        CLK_SYS,
	input wire logic        NRST,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0]  S_AXI_WSTRB,
	input wire logic        S_AXI_WVALID,
	input wire logic        S_AXI_WREADY,
	input wire logic        S_AXI_BVALID,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic        S_AXI_ARVALID,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic        S_AXI_RVALID,
	input wire logic        CPU_RESET_REQ,
	input wire logic        CPU_NMI,
	input wire logic        IRQ
);
	localparam logic [31:0] A_CTL = {18'h0, `WDRNM_IDX_CONTROL, 2'h0};
	localparam logic [31:0] A_RST = {18'h0, `WDRNM_IDX_RESTART, 2'h0};
	localparam logic [31:0] A_MSK = {18'h0, `WDRNM_IDX_IRQ_MASK, 2'h0};
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	// transfers taken this edge; writes here always offer address and data together
	wire w_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	wire r_take = S_AXI_ARVALID && S_AXI_ARREADY;

	property p_idle_after_reset;
		$rose(NRST) |-> S_AXI_AWREADY && S_AXI_ARREADY && !S_AXI_BVALID && !CPU_NMI
			&& !CPU_RESET_REQ && !IRQ;
	endproperty
	a_idle_after_reset: assert property (p_idle_after_reset)
		else $error("outputs not idle after reset");
	property p_nmi_pulse;
		CPU_NMI |=> !CPU_NMI;
	endproperty
	a_nmi_pulse: assert property (p_nmi_pulse)
		else $error("nmi longer than one cycle");
	property p_reset_req_holds;
		CPU_RESET_REQ |=> CPU_RESET_REQ;
	endproperty
	a_reset_req_holds: assert property (p_reset_req_holds)
		else $error("cpu reset request dropped");
	property p_nmi_not_reset;
		$rose(CPU_NMI) |-> !CPU_RESET_REQ;
	endproperty
	a_nmi_not_reset: assert property (p_nmi_not_reset)
		else $error("nmi and reset request together");
	property p_restart_reads_zero;
		r_take && S_AXI_ARADDR == A_RST |=> S_AXI_RVALID && S_AXI_RDATA == 32'h00000000;
	endproperty
	a_restart_reads_zero: assert property (p_restart_reads_zero)
		else $error("restart key read not zero");
	property p_write_answer;
		w_take |=> !S_AXI_BVALID ##1 S_AXI_BVALID;
	endproperty
	a_write_answer: assert property (p_write_answer)
		else $error("write answer not two edges after take");
	property p_irq_mask_off;
		w_take && S_AXI_AWADDR == A_MSK && S_AXI_WSTRB[0] && S_AXI_WDATA[1:0] == 2'h0
			|-> ##[1:3] !IRQ;
	endproperty
	a_irq_mask_off: assert property (p_irq_mask_off)
		else $error("interrupt stays high with mask cleared");
	property p_ctl_upper_zero;
		r_take && S_AXI_ARADDR == A_CTL |=> S_AXI_RDATA[31:8] == 24'h000000 && !S_AXI_RDATA[2];
	endproperty
	a_ctl_upper_zero: assert property (p_ctl_upper_zero)
		else $error("control read shows reserved bits");
endmodule // wdrnm_checker

bind wdrnm_top wdrnm_checker wdrnm_checker_inst (
	.CLK_SYS(CLK_SYS), .NRST(NRST), .S_AXI_AWADDR(S_AXI_AWADDR),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
	.CPU_RESET_REQ(CPU_RESET_REQ), .CPU_NMI(CPU_NMI), .IRQ(IRQ)
);

//--- tb/wdrnm_cpu_model.sv
// cpu core model that takes the watchdog reset request or nmi
`timescale 1ns/1ps
module wdrnm_cpu_model (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       cpu_reset_req,
	input  wire logic       cpu_nmi,
	output logic [7:0]      nmi_count,
	output logic            reset_seen
);
	// each nmi cycle is one interrupt; a reset request sticks until the chip reset
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			nmi_count <= 8'h00;
			reset_seen <= 1'b0;
		end else begin
			nmi_count <= nmi_count + {7'h00, cpu_nmi};
			reset_seen <= reset_seen | cpu_reset_req;
		end
	end
endmodule // wdrnm_cpu_model

//--- tb/test_watchdog_reset_nmi_timer.sv
// self-checking bench for the watchdog: register table, restart key, nmi time-out
`timescale 1ns/1ps
`include "wdrnm_consts.svh"
`define CHECK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module test_watchdog_reset_nmi_timer;
	localparam logic [31:0] A_CTL = {18'h0, `WDRNM_IDX_CONTROL, 2'h0};
	localparam logic [31:0] A_RST = {18'h0, `WDRNM_IDX_RESTART, 2'h0};
	localparam logic [31:0] A_STA = {18'h0, `WDRNM_IDX_IRQ_STATUS, 2'h0};
	localparam logic [31:0] A_MSK = {18'h0, `WDRNM_IDX_IRQ_MASK, 2'h0};
	localparam logic [1:0]  OK = `WDRNM_RESP_OKAY;
	localparam logic [1:0]  ER = `WDRNM_RESP_SLVERR;
	localparam int          PER = 262144;
	// no shortening parameter exists, so one full shortest period must run
	localparam int          LIMIT = 300000;
	typedef struct packed {
		logic        wr;
		logic [31:0] addr;
		logic [7:0]  data;
		logic [1:0]  resp;
	} wdrnm_row_t;
	logic        clk_sys;
	logic        nrst = 1'b0, rst_by_wd = 1'b0, rtc_tick = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rd;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0]  resp;
	wire         awready, wready, bvalid, arready, rvalid, cpu_reset_req, cpu_nmi, irq;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [7:0]  nmi_count;
	wire         reset_seen;
	int          mismatches = 0, n_compared = 0, cyc = 0, t_rst;
	// ordinary accesses: data is the written byte, or the expected read byte
	wdrnm_row_t rows [12] = '{
		'{1'b0, A_CTL, 8'h00, OK},
		'{1'b1, A_CTL, 8'h6F, OK},
		'{1'b0, A_CTL, 8'h4B, OK},
		'{1'b1, A_RST, 8'hA5, OK},
		'{1'b0, A_RST, 8'h00, OK},
		'{1'b1, 32'h300, 8'h00, ER},
		'{1'b0, 32'h300, 8'h00, ER},
		'{1'b1, A_MSK, 8'h03, OK},
		'{1'b0, A_MSK, 8'h03, OK},
		'{1'b1, A_CTL, 8'hC3, OK}, // shortest period keeps the run brief
		'{1'b1, A_CTL, 8'h43, OK},
		'{1'b0, A_CTL, 8'hC3, OK}
	};

	wdrnm_top wdrnm_top_inst (
		.CLK_SYS(clk_sys), .NRST(nrst), .RST_BY_WATCHDOG(rst_by_wd), .RTC_TICK(rtc_tick),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.CPU_RESET_REQ(cpu_reset_req), .CPU_NMI(cpu_nmi), .IRQ(irq)
	);
	wdrnm_cpu_model wdrnm_cpu_model_inst (
		.clk_sys(clk_sys), .nrst(nrst), .cpu_reset_req(cpu_reset_req), .cpu_nmi(cpu_nmi),
		.nmi_count(nmi_count), .reset_seen(reset_seen)
	);

	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// real-time ticks stay running; they must not move the system-clock count
	always @(posedge clk_sys) begin
		rtc_tick <= ~rtc_tick;
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// address and data offered together, each dropped once taken
	task automatic axi_write(input logic [31:0] a, input logic [7:0] d);
		bit aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_sys);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [31:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_sys); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys); while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
		axi_read(a);
		`CHECK("read data", {24'h000000, e}, rd)
	endtask
	task automatic do_reset(input logic by_wd);
		@(posedge clk_sys);
		nrst <= 1'b0;
		rst_by_wd <= by_wd;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		rst_by_wd <= 1'b0;
	endtask

	// table, then restart key timing, nmi time-out and the two kinds of reset
	initial begin
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_write(rows[i].addr, rows[i].data);
			end else begin
				axi_read(rows[i].addr);
				if (rows[i].resp === OK)
					`CHECK("row data", {24'h000000, rows[i].data}, rd)
			end
			`CHECK("row resp", rows[i].resp, resp)
		end
		axi_write(A_RST, 8'hA5);
		repeat (400) @(posedge clk_sys);
		axi_write(A_RST, 8'h5A);
		t_rst = cyc;
		repeat (2000) @(posedge clk_sys);
		axi_write(A_RST, 8'hA5);
		axi_write(A_RST, 8'h33);
		axi_write(A_RST, 8'h5A);
		while (cpu_nmi !== 1'b1) @(posedge clk_sys);
		`CHECK("delay", 1'b1, (cyc - t_rst) inside {[PER - 3:PER + 3]})
		repeat (3) @(posedge clk_sys);
		`CHECK("nmi count", 8'h01, nmi_count)
		`CHECK("reset seen", 1'b0, reset_seen)
		`CHECK("irq", 1'b1, irq)
		rd_chk(A_STA, 8'h03);
		rd_chk(A_CTL, 8'hE3);
		axi_write(A_MSK, 8'h00);
		// the mask lands with the write, the registered output follows one edge later
		repeat (2) @(posedge clk_sys);
		`CHECK("irq masked", 1'b0, irq)
		axi_write(A_STA, 8'h03);
		rd_chk(A_STA, 8'h00);
		do_reset(1'b1);
		rd_chk(A_CTL, 8'h20);
		do_reset(1'b0);
		rd_chk(A_CTL, 8'h00);
		print_verdict();
	end
endmodule // test_watchdog_reset_nmi_timer
